// ### src/bccc_defs.vh
// Constants for the charge cycle sequencer: offsets, fields, resets, timing.
// Assumes a 10 MHz core clock and a 32-bit Avalon-MM register port.
`ifndef BCCC_DEFS_VH
`define BCCC_DEFS_VH

// ----------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------
`define BCCC_OFS_CTRL      4'h0
`define BCCC_OFS_FAST      4'h1
`define BCCC_OFS_PRE       4'h2
`define BCCC_OFS_VOLT      4'h3
`define BCCC_OFS_TIMER     4'h4
`define BCCC_OFS_STATUS    4'h5

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define BCCC_CTL_CHG_EN    0
`define BCCC_CTL_TERM_EN   1
`define BCCC_CTL_HALF_EN   2
`define BCCC_CTL_SW_OFF    3
`define BCCC_CTL_WARM_SEL  4
`define BCCC_CTL_COOL_SEL  5
`define BCCC_CTL_RECHG_SEL 6
`define BCCC_CTL_IND_LO    8
`define BCCC_CTL_IND_HI    9
`define BCCC_CTL_RESTORE   31
`define BCCC_RST_CTRL      10'h007

// ----------------------------------------------------------------------
// Reset values (currents and voltages in mA and mV)
// ----------------------------------------------------------------------
`define BCCC_RST_FAST      12'h800
`define BCCC_RST_PRE       12'h0b4
`define BCCC_RST_TERM      12'h0b4
`define BCCC_RST_SHORT     12'h064
`define BCCC_RST_CHARGE_VOLTAGE_SETTING      13'h1070
`define BCCC_WARM_CHARGE_VOLTAGE_SETTING     13'h1004
`define BCCC_RST_SAFE_H    4'ha
`define BCCC_RST_TOPOFF    2'h0

// ----------------------------------------------------------------------
// Phase and fault codes
// ----------------------------------------------------------------------
`define BCCC_PH_OFF        2'h0
`define BCCC_PH_PRE        2'h1
`define BCCC_PH_FAST       2'h2
`define BCCC_PH_DONE       2'h3
`define BCCC_FLT_NONE      2'h0
`define BCCC_FLT_SAFETY    2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BCCC_CLK_HZ        10000000
`define BCCC_TICK_S        1
`define BCCC_SEC_PER_HOUR  16'd3600
`define BCCC_SEC_PER_MIN   12'd60
`define BCCC_TOPOFF_STEP   12'd15
`define BCCC_SYNC_W        13

`endif

// ### src/bccc_ctrl.v
// Charge cycle sequencer: state machine, timers, register port, indicator.
// Assumes comparator and pin levels arrive asynchronously; Avalon master
// holds each request until it samples waitrequest low.
//
// Contract
// - Run a full charge cycle while enable bit is 1 and enable pin low.
// - Reset defaults: 4.208 V, 2.048 A fast, 180 mA pre/term, 10 h timer.
// - Start only with converter, enable, nonzero fast current, no faults, switch on.
// - Terminate on low current and high voltage, not during regulation.
// - Done battery below recharge threshold starts a new cycle.
// - Toggling enable pin or bit after done restarts charging.
// - Indicator low charging, high done/off, blinking fault; off when field 11.
// - Phase reads 00 off, 01 precharge, 10 fast, 11 done.
// - Interrupt once a charge cycle completes.
// - Current from battery voltage: short, precharge, fast with phases.
// - Regulation suspends termination and halves safety timer rate.
// - On completion open battery switch; close again for supplement.
// - Termination sets phase 11 and pulses interrupt.
// - Termination enable bit 0 inhibits termination.
// - Top-off timer after termination follows safety timer pause and slowdown.
// - Status bit shows top-off timer running.
// - Clear top-off timer on enable rise, termination rise, defaults restore.
// - Top-off setting latched at termination; later writes wait for recharge.
// - Interrupt at top-off start and at top-off expiry.
// - Charge only inside T1..T5 window; suspend outside until back.
// - Warm band regulates to programmed voltage or 4.1 V per select.
// - Cool band reduces current, selectable down to 20 percent of fast.
// - Safety timer expiry sets fault field 11 and interrupts.
// - Half-rate enable bit 0 stops safety timer slowing.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "bccc_defs.vh"

module bccc_ctrl #(
  parameter TICK_CYCLES = `BCCC_TICK_S * `BCCC_CLK_HZ
) (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        reset_in,
  // Avalon-MM slave
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // Asynchronous status pins and comparators
  input  wire        charge_enable_n_in,
  input  wire        temp_in_window_in,
  input  wire        temp_cool_in,
  input  wire        temp_warm_in,
  input  wire        bat_below_short_in,
  input  wire        bat_below_fast_in,
  input  wire        bat_above_rechg_in,
  input  wire        cur_below_term_in,
  input  wire        converter_running_in,
  input  wire        in_cur_reg_in,
  input  wire        in_volt_reg_in,
  input  wire        thermal_reg_in,
  input  wire        sys_below_bat_in,
  // Power stage control
  output wire [11:0] charge_current_ma_out,
  output wire [12:0] charge_voltage_mv_out,
  output wire        charging_out,
  output wire        battery_switch_out,
  output wire        recharge_threshold_select_out,
  output wire [11:0] term_current_ma_out,
  // Indicator pin (open drain) and host interrupt
  output wire        indicator_pin_out,
  output wire        indicator_pin_oe_out,
  output wire        host_irq_out
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [4:0] ST_OFF  = 5'h01;
  localparam [4:0] ST_CHG  = 5'h02;
  localparam [4:0] ST_SUSP = 5'h04;
  localparam [4:0] ST_DONE = 5'h08;
  localparam [4:0] ST_FLT  = 5'h10;

  function [11:0] cool_current;
    input [11:0] fast;
    input        fifth;
    begin
      if (fifth)
        cool_current = fast / 12'd5;
      else
        cool_current = {1'b0, fast[11:1]};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  wire [`BCCC_SYNC_W-1:0] raw = {sys_below_bat_in, thermal_reg_in, in_volt_reg_in,
    in_cur_reg_in, converter_running_in, cur_below_term_in, bat_above_rechg_in,
    bat_below_fast_in, bat_below_short_in, temp_warm_in, temp_cool_in,
    temp_in_window_in, charge_enable_n_in};
  reg [`BCCC_SYNC_W-1:0] s1_q;
  reg [`BCCC_SYNC_W-1:0] s2_q;
  reg [`BCCC_SYNC_W-1:0] s3_q;
  reg [`BCCC_SYNC_W-1:0] pin_q;
  integer i;

  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      // Idle levels, so the enable pin shows no false edge after reset
      s1_q  <= 13'h0001;
      s2_q  <= 13'h0001;
      s3_q  <= 13'h0001;
      pin_q <= 13'h0001;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < `BCCC_SYNC_W; i = i + 1)
        if (s2_q[i] == s3_q[i])
          pin_q[i] <= s2_q[i];
    end
  end

  wire ce_n     = pin_q[0];
  wire temp_ok  = pin_q[1];
  wire cool     = pin_q[2];
  wire warm     = pin_q[3];
  wire bat_shrt = pin_q[4];
  wire bat_pre  = pin_q[5];
  wire bat_high = pin_q[6];
  wire cur_low  = pin_q[7];
  wire conv_on  = pin_q[8];
  wire in_reg   = pin_q[9] | pin_q[10] | pin_q[11];
  wire sys_low  = pin_q[12];

  // ----------------------------------------------------------------------
  // Register file and Avalon slave
  // ----------------------------------------------------------------------
  reg  [9:0]  ctrl_q;
  reg  [11:0] fast_q;
  reg  [11:0] pre_q;
  reg  [11:0] term_q;
  reg  [11:0] short_q;
  reg  [12:0] charge_voltage_setting_q;
  reg  [3:0]  safe_h_q;
  reg  [1:0]  topoff_set_q;
  reg         wait_q;
  reg  [31:0] rdata_q;
  reg         restore_q;
  reg  [4:0]  st_q;
  reg  [1:0]  phase_q;
  reg  [1:0]  fault_q;
  reg         topoff_run_q;
  wire        req    = avs_read_in | avs_write_in;
  wire        access = req & ~wait_q;
  wire        wr     = access & avs_write_in;

  always @(posedge core_clk_in)
  begin
    if (reset_in | restore_q)
    begin
      ctrl_q       <= `BCCC_RST_CTRL;
      fast_q       <= `BCCC_RST_FAST;
      pre_q        <= `BCCC_RST_PRE;
      term_q       <= `BCCC_RST_TERM;
      short_q      <= `BCCC_RST_SHORT;
      charge_voltage_setting_q       <= `BCCC_RST_CHARGE_VOLTAGE_SETTING;
      safe_h_q     <= `BCCC_RST_SAFE_H;
      topoff_set_q <= `BCCC_RST_TOPOFF;
    end
    else if (wr)
    begin
      case (avs_address_in)
        `BCCC_OFS_CTRL:  ctrl_q <= avs_writedata_in[9:0];
        `BCCC_OFS_FAST:  fast_q <= avs_writedata_in[11:0];
        `BCCC_OFS_PRE:
        begin
          pre_q  <= avs_writedata_in[11:0];
          term_q <= avs_writedata_in[27:16];
        end
        `BCCC_OFS_VOLT:
        begin
          short_q <= avs_writedata_in[11:0];
          charge_voltage_setting_q  <= avs_writedata_in[28:16];
        end
        `BCCC_OFS_TIMER:
        begin
          safe_h_q     <= avs_writedata_in[3:0];
          topoff_set_q <= avs_writedata_in[9:8];
        end
        default: ;
      endcase
    end
  end

  // Waitrequest drops for exactly one cycle per request
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      wait_q    <= 1'b1;
      rdata_q   <= 32'h0;
      restore_q <= 1'b0;
    end
    else
    begin
      wait_q    <= ~(req & wait_q);
      restore_q <= wr & (avs_address_in == `BCCC_OFS_CTRL) &
                   avs_writedata_in[`BCCC_CTL_RESTORE];
      if (req & wait_q)
      begin
        case (avs_address_in)
          `BCCC_OFS_CTRL:   rdata_q <= {22'h0, ctrl_q};
          `BCCC_OFS_FAST:   rdata_q <= {20'h0, fast_q};
          `BCCC_OFS_PRE:    rdata_q <= {4'h0, term_q, 4'h0, pre_q};
          `BCCC_OFS_VOLT:   rdata_q <= {3'h0, charge_voltage_setting_q, 4'h0, short_q};
          `BCCC_OFS_TIMER:  rdata_q <= {22'h0, topoff_set_q, 4'h0, safe_h_q};
          `BCCC_OFS_STATUS: rdata_q <= {23'h0, topoff_run_q, 2'h0, fault_q,
                                        2'h0, phase_q};
          default:          rdata_q <= 32'h0;
        endcase
      end
      else
        rdata_q <= 32'h0;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;

  // ----------------------------------------------------------------------
  // Enable, start conditions, time base
  // ----------------------------------------------------------------------
  wire enable   = ctrl_q[`BCCC_CTL_CHG_EN] & ~ce_n;
  wire term_en  = ctrl_q[`BCCC_CTL_TERM_EN];
  wire half_en  = ctrl_q[`BCCC_CTL_HALF_EN];
  wire can_go   = conv_on & enable & (fast_q != 12'h0) & temp_ok &
                  ~ctrl_q[`BCCC_CTL_SW_OFF];
  reg  enable_q;
  reg  [31:0] tick_cnt_q;
  reg  tick_q;
  reg  half_ph_q;
  reg  blink_q;
  wire en_rise  = enable & ~enable_q;
  wire slow     = in_reg & half_en;
  wire step     = tick_q & (~slow | half_ph_q);

  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      enable_q   <= 1'b0;
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
      half_ph_q  <= 1'b0;
      blink_q    <= 1'b0;
    end
    else
    begin
      enable_q <= enable;
      tick_q   <= (tick_cnt_q == TICK_CYCLES - 1);
      if (tick_cnt_q == TICK_CYCLES - 1)
      begin
        tick_cnt_q <= 32'h0;
        blink_q    <= ~blink_q;
      end
      else
        tick_cnt_q <= tick_cnt_q + 32'h1;
      if (tick_q)
        half_ph_q <= ~half_ph_q;
    end
  end

  // ----------------------------------------------------------------------
  // Charge state machine and timers
  // ----------------------------------------------------------------------
  reg  [15:0] safe_cnt_q;
  reg  [11:0] top_cnt_q;
  reg  [1:0]  top_lat_q;
  reg         irq_q;
  wire [15:0] safe_lim = {12'h0, safe_h_q} * `BCCC_SEC_PER_HOUR;
  wire [11:0] top_lim  = {10'h0, top_lat_q} * `BCCC_TOPOFF_STEP * `BCCC_SEC_PER_MIN;
  wire        term_hit = cur_low & bat_high & ~in_reg & term_en;

  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      st_q         <= ST_OFF;
      fault_q      <= `BCCC_FLT_NONE;
      safe_cnt_q   <= 16'h0;
      top_cnt_q    <= 12'h0;
      top_lat_q    <= 2'h0;
      topoff_run_q <= 1'b0;
      irq_q        <= 1'b0;
    end
    else
    begin
      irq_q <= 1'b0;
      if (en_rise | restore_q)
      begin
        top_cnt_q    <= 12'h0;
        topoff_run_q <= 1'b0;
      end
      case (st_q)
        ST_OFF:
        begin
          safe_cnt_q <= 16'h0;
          if (can_go & (fault_q == `BCCC_FLT_NONE))
            st_q <= ST_CHG;
        end
        ST_CHG:
        begin
          if (~enable | ~conv_on | ctrl_q[`BCCC_CTL_SW_OFF])
            st_q <= ST_OFF;
          else if (~temp_ok)
            st_q <= ST_SUSP;
          else if (term_hit)
          begin
            st_q      <= ST_DONE;
            irq_q     <= 1'b1;
            top_lat_q <= topoff_set_q;
            top_cnt_q <= 12'h0;
            topoff_run_q <= (topoff_set_q != 2'h0);
          end
          else if ((safe_h_q != 4'h0) & (safe_cnt_q >= safe_lim))
          begin
            st_q    <= ST_FLT;
            fault_q <= `BCCC_FLT_SAFETY;
            irq_q   <= 1'b1;
          end
          else if (step)
            safe_cnt_q <= safe_cnt_q + 16'h1;
        end
        ST_SUSP:
        begin
          if (~enable)
            st_q <= ST_OFF;
          else if (temp_ok)
            st_q <= ST_CHG;
        end
        ST_DONE:
        begin
          if (en_rise)
            st_q <= ST_CHG;
          else if (~enable)
            st_q <= ST_OFF;
          else if (~bat_high)
          begin
            st_q         <= ST_OFF;
            topoff_run_q <= 1'b0;
          end
          else if (topoff_run_q & temp_ok & step)
          begin
            if (top_cnt_q >= top_lim - 12'h1)
            begin
              topoff_run_q <= 1'b0;
              irq_q        <= 1'b1;
            end
            else
              top_cnt_q <= top_cnt_q + 12'h1;
          end
        end
        ST_FLT:
        begin
          if (en_rise)
          begin
            fault_q <= `BCCC_FLT_NONE;
            st_q    <= ST_OFF;
          end
        end
        default: st_q <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs: phase, current, voltage, switch, indicator
  // ----------------------------------------------------------------------
  reg  [11:0] cur_q;
  reg  [12:0] volt_q;
  reg         chg_q;
  reg         sw_q;
  reg         ind_oe_q;
  wire        charging = (st_q == ST_CHG);
  wire [11:0] fast_eff = cool ? cool_current(fast_q, ctrl_q[`BCCC_CTL_COOL_SEL])
                              : fast_q;

  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      phase_q  <= `BCCC_PH_OFF;
      cur_q    <= 12'h0;
      volt_q   <= `BCCC_RST_CHARGE_VOLTAGE_SETTING;
      chg_q    <= 1'b0;
      sw_q     <= 1'b1;
      ind_oe_q <= 1'b0;
    end
    else
    begin
      // Drops with the switch, not a cycle after it
      chg_q <= charging & ~ctrl_q[`BCCC_CTL_SW_OFF];
      if (st_q == ST_DONE)
        phase_q <= `BCCC_PH_DONE;
      else if (charging | (st_q == ST_SUSP))
        phase_q <= bat_pre ? `BCCC_PH_PRE : `BCCC_PH_FAST;
      else
        phase_q <= `BCCC_PH_OFF;
      if (~charging)
        cur_q <= 12'h0;
      else if (bat_shrt)
        cur_q <= short_q;
      else if (bat_pre)
        cur_q <= pre_q;
      else
        cur_q <= fast_eff;
      volt_q <= (warm & ctrl_q[`BCCC_CTL_WARM_SEL]) ? `BCCC_WARM_CHARGE_VOLTAGE_SETTING : charge_voltage_setting_q;
      // Done opens the switch but supplement mode may reclose it
      sw_q <= ~ctrl_q[`BCCC_CTL_SW_OFF] & ((st_q != ST_DONE) | sys_low);
      if (ctrl_q[`BCCC_CTL_IND_HI:`BCCC_CTL_IND_LO] == 2'h3)
        ind_oe_q <= 1'b0;
      else if ((st_q == ST_FLT) | (st_q == ST_SUSP))
        ind_oe_q <= blink_q;
      else
        ind_oe_q <= charging;
    end
  end

  assign charge_current_ma_out         = cur_q;
  assign charge_voltage_mv_out         = volt_q;
  assign charging_out                  = chg_q;
  assign battery_switch_out            = sw_q;
  assign recharge_threshold_select_out = ctrl_q[`BCCC_CTL_RECHG_SEL];
  assign term_current_ma_out           = term_q;
  assign indicator_pin_out             = 1'b0;
  assign indicator_pin_oe_out          = ind_oe_q;
  assign host_irq_out                  = irq_q;

endmodule
`default_nettype wire

// ### test/bccc_ctrl_checker.sv
// Concurrent checks on the charge sequencer's ports.
// Assumes it is bound onto bccc_ctrl; single clock domain.
`timescale 1ns/10ps
`default_nettype none
module bccc_ctrl_checker (
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  // Register port
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Power stage and pins
  input wire logic [11:0] charge_current_ma_out,
  input wire logic [12:0] charge_voltage_mv_out,
  input wire logic        charging_out,
  input wire logic        battery_switch_out,
  input wire logic [11:0] term_current_ma_out,
  input wire logic        indicator_pin_out,
  input wire logic        host_irq_out
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_wait_ans;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  property p_wait_one;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_rd_idle;
    avs_waitrequest_out |-> avs_readdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_rst_vals;
    $fell(reset_in) |-> charge_voltage_mv_out == 13'h1070 && !charging_out && !host_irq_out;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("wrong values after reset");
  property p_term_hold;
    $changed(term_current_ma_out) |-> $past(avs_write_in) || $past(avs_write_in, 2);
  endproperty
  a_term_hold: assert property (p_term_hold) else $error("setting moved unasked");
  property p_irq_pulse;
    host_irq_out |=> !host_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");
  property p_idle_cur;
    !charging_out && $past(!charging_out) |-> charge_current_ma_out == 12'h0;
  endproperty
  a_idle_cur: assert property (p_idle_cur) else $error("current while idle");
  property p_sw_closed;
    charging_out |-> battery_switch_out;
  endproperty
  a_sw_closed: assert property (p_sw_closed) else $error("switch open in charge");
  property p_od_low;
    indicator_pin_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("indicator drives high");
endmodule
`default_nettype wire

// ### test/bccc_batt_model.sv
// Behavioural battery and current sense comparators.
// Assumes level 0 short, 1 precharge, 2 fast, 3 full.
`timescale 1ns/10ps
`default_nettype none
module bccc_batt_model (
  // Control
  input  wire logic [1:0] level_in,
  input  wire logic       charging_in,
  // Comparators
  output logic            below_short_out,
  output logic            below_fast_out,
  output logic            above_rechg_out,
  output logic            cur_low_out
);
  assign below_short_out = (level_in == 2'h0);
  assign below_fast_out  = (level_in <= 2'h1);
  assign above_rechg_out = (level_in == 2'h3);
  // Current tapers only once full and being charged
  assign cur_low_out     = (level_in == 2'h3) && charging_in;
endmodule
`default_nettype wire

// ### test/bccc_tb.sv
// Self-checking bench for the charge sequencer.
// Assumes TICK_CYCLES of 2, so one timer second is two clocks.
`timescale 1ns/10ps
`default_nettype none
`include "bccc_defs.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        en_n = 1'b1;
  logic        win = 1'b1;
  logic        cool = 1'b0;
  logic        warm = 1'b0;
  logic        icr = 1'b0;
  logic        sysl = 1'b0;
  logic [1:0]  lvl = 2'h2;
  wire  [31:0] rdata;
  wire  [11:0] cur;
  wire  [12:0] vmv;
  wire  [11:0] tcur;
  wire         wt, chg, sw, oe, irq, bs, bf, br, ct, rsel;
  int          err_count = 0;
  int          n_compared = 0;

  always #50 clk = ~clk;

  bccc_batt_model i_bccc_batt_model (.level_in(lvl), .charging_in(chg),
    .below_short_out(bs), .below_fast_out(bf), .above_rechg_out(br), .cur_low_out(ct));
  bccc_ctrl #(.TICK_CYCLES(2)) i_bccc_ctrl (
    .core_clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wt), .charge_enable_n_in(en_n), .temp_in_window_in(win),
    .temp_cool_in(cool), .temp_warm_in(warm), .bat_below_short_in(bs),
    .bat_below_fast_in(bf), .bat_above_rechg_in(br), .cur_below_term_in(ct),
    .converter_running_in(1'b1), .in_cur_reg_in(icr), .in_volt_reg_in(1'b0),
    .thermal_reg_in(1'b0), .sys_below_bat_in(sysl), .charge_current_ma_out(cur),
    .charge_voltage_mv_out(vmv), .charging_out(chg), .battery_switch_out(sw),
    .recharge_threshold_select_out(rsel), .term_current_ma_out(tcur), .indicator_pin_out(),
    .indicator_pin_oe_out(oe), .host_irq_out(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("errors=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (n >= 50)
      err_count++;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wchg(input logic v);
    int n;
    n = 0;
    while (chg !== v && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(chg, v);
  endtask
  task wirq(input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < lim);
    chk(irq, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    rchk(4'h0, 32'hffffffff, 32'h7);
    rchk(4'h1, 32'hffffffff, 32'h800);
    rchk(4'h2, 32'hffffffff, 32'h00b400b4);
    rchk(4'h3, 32'hffffffff, 32'h10700064);
    rchk(4'h4, 32'hffffffff, 32'ha);
    rchk(4'h5, 32'hffffffff, 32'h0);
    rchk(4'h7, 32'hffffffff, 32'h0);
    chk(tcur, 32'h0b4);
    chk(rsel, 1'b0);
  endtask
  task t_charge;
    @(posedge clk) en_n <= 1'b0;
    wchg(1'b1);
    chk(cur, 12'h800);
    rchk(4'h5, 32'h3, 32'h2);
    chk(oe, 1'b1);
    wreg(4'h0, 32'h347);
    cyc(4);
    chk(oe, 1'b0);
    chk(rsel, 1'b1);
    wreg(4'h0, 32'h7);
    @(posedge clk) lvl <= 2'h1;
    cyc(8);
    chk(cur, 12'h0b4);
    rchk(4'h5, 32'h3, 32'h1);
    @(posedge clk) lvl <= 2'h0;
    cyc(8);
    chk(cur, 12'h064);
    @(posedge clk) lvl <= 2'h2;
    cyc(8);
  endtask
  task t_jeita;
    @(posedge clk) warm <= 1'b1;
    wreg(4'h0, 32'h17);
    cyc(8);
    chk(vmv, 13'h1004);
    wreg(4'h0, 32'h7);
    cyc(4);
    chk(vmv, 13'h1070);
    @(posedge clk) warm <= 1'b0;
    @(posedge clk) cool <= 1'b1;
    cyc(8);
    chk(cur, 12'h400);
    wreg(4'h0, 32'h27);
    cyc(4);
    chk(cur, 12'h199);
    wreg(4'h0, 32'h7);
    @(posedge clk) cool <= 1'b0;
    cyc(8);
  endtask
  task t_window;
    @(posedge clk) win <= 1'b0;
    wchg(1'b0);
    @(posedge clk) win <= 1'b1;
    wchg(1'b1);
  endtask
  task t_term;
    wreg(4'h4, 32'h10a);
    wreg(4'h0, 32'h5);
    @(posedge clk) lvl <= 2'h3;
    cyc(20);
    chk(chg, 1'b1);
    @(posedge clk) icr <= 1'b1;
    cyc(6);
    wreg(4'h0, 32'h7);
    cyc(20);
    chk(chg, 1'b1);
    @(posedge clk) icr <= 1'b0;
    wirq(50);
    cyc(2);
    chk(chg, 1'b0);
    chk(sw, 1'b0);
    @(posedge clk) sysl <= 1'b1;
    cyc(8);
    chk(sw, 1'b1);
    @(posedge clk) sysl <= 1'b0;
    rchk(4'h5, 32'h133, 32'h103);
    wirq(2500);
    rchk(4'h5, 32'h100, 32'h0);
    wreg(4'h4, 32'ha);
  endtask
  task t_restart;
    wreg(4'h0, 32'h6);
    wreg(4'h0, 32'h7);
    wchg(1'b1);
    wirq(200);
    @(posedge clk) lvl <= 2'h2;
    wchg(1'b1);
  endtask
  task t_safety;
    logic o;
    wreg(4'h4, 32'h1);
    wreg(4'h0, 32'h6);
    @(posedge clk) icr <= 1'b1;
    cyc(6);
    wreg(4'h0, 32'h3);
    wirq(8000);
    @(posedge clk) icr <= 1'b0;
    rchk(4'h5, 32'h30, 32'h30);
    chk(chg, 1'b0);
    o = oe;
    cyc(2);
    chk(oe, !o);
    wreg(4'h4, 32'ha);
    wreg(4'h0, 32'h6);
    wreg(4'h0, 32'h7);
    wchg(1'b1);
  endtask
  task t_nofast;
    wreg(4'h1, 32'h0);
    wreg(4'h0, 32'h6);
    wreg(4'h0, 32'h7);
    cyc(20);
    chk(chg, 1'b0);
    wreg(4'h1, 32'h800);
    wchg(1'b1);
    wreg(4'h0, 32'hf);
    wchg(1'b0);
    chk(sw, 1'b0);
    wreg(4'h0, 32'h7);
    wchg(1'b1);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    t_defaults;
    t_charge;
    t_jeita;
    t_window;
    t_term;
    t_restart;
    t_safety;
    t_nofast;
    end_sim;
  end
  // Run needs about 9500 clocks
  initial
  begin
    #5000000;
    err_count++;
    end_sim;
  end
endmodule

bind bccc_ctrl bccc_ctrl_checker i_bccc_ctrl_checker (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .charge_current_ma_out(charge_current_ma_out),
  .charge_voltage_mv_out(charge_voltage_mv_out), .charging_out(charging_out),
  .battery_switch_out(battery_switch_out), .term_current_ma_out(term_current_ma_out),
  .indicator_pin_out(indicator_pin_out), .host_irq_out(host_irq_out));
`default_nettype wire
